// ### nirq_pkg.sv
package nirq_pkg;

   // Register byte addresses of the common block
   localparam logic [23:0] ADDR_INTERRUPT_CAUSE = 24'hfe0015;
   localparam logic [23:0] ADDR_SOCKET_INTERRUPT_MASK = 24'hfe0016;
   localparam logic [23:0] ADDR_RETRY_PERIOD_HI = 24'hfe0017;
   localparam logic [23:0] ADDR_RETRY_PERIOD_LO = 24'hfe0018;
   localparam logic [23:0] ADDR_RETRY_LIMIT = 24'hfe0019;
   localparam logic [23:0] ADDR_PPP_AUTH_TYPE_HI = 24'hfe001c;
   localparam logic [23:0] ADDR_PPP_AUTH_TYPE_LO = 24'hfe001d;
   localparam logic [23:0] ADDR_PPP_AUTH_ALGORITHM = 24'hfe001e;
   localparam logic [23:0] ADDR_CHIP_VERSION = 24'hfe001f;
   localparam logic [23:0] ADDR_LCP_ECHO_INTERVAL = 24'hfe0028;
   localparam logic [23:0] ADDR_LCP_MAGIC_NUMBER = 24'hfe0029;
   localparam logic [23:0] ADDR_REASSERT_DELAY_HI = 24'hfe0030;
   localparam logic [23:0] ADDR_REASSERT_DELAY_LO = 24'hfe0031;
   localparam logic [23:0] ADDR_SOCKET_SUMMARY = 24'hfe0034;

   // Cause register fields
   localparam int CAUSE_CONFLICT_BIT = 7;
   localparam int CAUSE_DEST_UNREACHABLE_FLAG_BIT = 6;
   localparam int CAUSE_LINK_CLOSED_BIT = 5;
   localparam logic [7:0] CAUSE_IMPL_MASK = 8'he0;

   // Reset values
   localparam logic [7:0] RST_INTERRUPT_CAUSE = 8'h00;
   localparam logic [7:0] RST_SOCKET_INTERRUPT_MASK = 8'h00;
   localparam logic [15:0] RST_RETRY_PERIOD = 16'h07d0;
   localparam logic [7:0] RST_RETRY_LIMIT = 8'h08;
   localparam logic [15:0] RST_PPP_AUTH_TYPE = 16'h0000;
   localparam logic [7:0] RST_PPP_AUTH_ALGORITHM = 8'h00;
   localparam logic [7:0] RST_LCP_ECHO_INTERVAL = 8'h28;
   localparam logic [7:0] RST_LCP_MAGIC_NUMBER = 8'h00;
   localparam logic [15:0] RST_REASSERT_DELAY = 16'h0000;

   // Authentication type codes
   localparam logic [15:0] AUTH_TYPE_PASSWORD = 16'hc023;
   localparam logic [15:0] AUTH_TYPE_CHALLENGE = 16'hc223;

   // Timing
   localparam int CLOCK_PERIOD_NS = 8;
   localparam int RETRY_UNIT_NS = 100000;
   localparam int LCP_UNIT_NS = 25000000;
   localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_NS / CLOCK_PERIOD_NS;
   localparam int LCP_UNIT_CYCLES = LCP_UNIT_NS / CLOCK_PERIOD_NS;
   localparam logic [16:0] RETRY_WAIT_MAX = 17'h0ffff;

   typedef enum logic [1:0] {
      LINE_IDLE,
      LINE_ASSERTED,
      LINE_WAIT
   } nirq_line_type;

   typedef enum logic [1:0] {
      RETRY_IDLE,
      RETRY_WAITING,
      RETRY_DONE
   } nirq_retry_type;

endpackage

// ### nirq_tick_divider.sv
`timescale 1ns/100ps
`default_nettype none
module nirq_tick_divider #(
   parameter int CYCLES = 12500
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic restart,
   output logic tick
);

   logic [31:0] count_r;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_r <= 32'h0;
         tick <= 1'b0;
      end else if (restart) begin
         count_r <= 32'h0;
         tick <= 1'b0;
      end else if (count_r == 32'(CYCLES - 1)) begin
         count_r <= 32'h0;
         tick <= 1'b1;
      end else begin
         count_r <= count_r + 32'h1;
         tick <= 1'b0;
      end
   end

endmodule // nirq_tick_divider
`default_nettype wire

// ### nirq_retry_timer.sv
`timescale 1ns/100ps
`default_nettype none
module nirq_retry_timer (
   input wire logic clk,
   input wire logic rstn,
   input wire logic unit_tick,
   input wire logic start,
   input wire logic is_tcp,
   input wire logic [2:0] socket,
   input wire logic ack,
   input wire logic [15:0] period,
   input wire logic [7:0] limit,
   output logic resend,
   output logic [7:0] timeout,
   output logic [7:0] close,
   output logic busy
);

   nirq_pkg::nirq_retry_type state_r;
   logic [16:0] wait_r;
   logic [16:0] remain_r;
   logic [8:0] waits_r;
   logic tcp_r;
   logic [2:0] socket_r;
   logic [16:0] doubled;

   assign doubled = {wait_r[15:0], 1'b0};

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= nirq_pkg::RETRY_IDLE;
         wait_r <= 17'h0;
         remain_r <= 17'h0;
         waits_r <= 9'h0;
         tcp_r <= 1'b0;
         socket_r <= 3'h0;
         resend <= 1'b0;
         timeout <= 8'h0;
         close <= 8'h0;
      end else begin
         resend <= 1'b0;
         timeout <= 8'h0;
         close <= 8'h0;
         case (state_r)
            nirq_pkg::RETRY_IDLE, nirq_pkg::RETRY_DONE: begin
               state_r <= nirq_pkg::RETRY_IDLE;
               if (start) begin
                  state_r <= nirq_pkg::RETRY_WAITING;
                  wait_r <= {1'b0, period};
                  remain_r <= {1'b0, period};
                  waits_r <= 9'h0;
                  tcp_r <= is_tcp;
                  socket_r <= socket;
               end
            end
            nirq_pkg::RETRY_WAITING: begin
               if (ack) begin
                  state_r <= nirq_pkg::RETRY_IDLE;
               end else if (unit_tick && remain_r > 17'h1) begin
                  remain_r <= remain_r - 17'h1;
               end else if (unit_tick || remain_r == 17'h0) begin
                  // Limit plus one waits in all, then final timeout
                  if (waits_r == {1'b0, limit}) begin
                     state_r <= nirq_pkg::RETRY_DONE;
                     timeout[socket_r] <= 1'b1;
                     close[socket_r] <= tcp_r;
                  end else begin
                     resend <= 1'b1;
                     waits_r <= waits_r + 9'h1;
                     if (tcp_r && doubled <= nirq_pkg::RETRY_WAIT_MAX) begin
                        wait_r <= doubled;
                        remain_r <= doubled;
                     end else begin
                        remain_r <= wait_r;
                     end
                  end
               end
            end
            default: state_r <= nirq_pkg::RETRY_IDLE;
         endcase
      end
   end

   assign busy = (state_r == nirq_pkg::RETRY_WAITING);

endmodule // nirq_retry_timer
`default_nettype wire

// ### nirq_core.sv
// What this block does
// - Core interrupt line is low while any cause bit is set, except during a re-assert wait.
// - ARP request naming our own IP sets cause bit 7.
// - ICMP unreachable after UDP send sets cause bit 6.
// - PPP link closing in PPPoE mode sets cause bit 5.
// - Writing one clears a cause bit; bits 4 to 0 read zero.
// - Mask bit gates its socket summary bit onto the interrupt.
// - Retry period counts 100 us units, resets to 0x07d0.
// - Retry limit resets to 0x08; exceeding it flags socket timeout.
// - TCP final timeout closes the socket with the timeout flag.
// - ARP resent each period, limit plus one waits, then timeout.
// - TCP wait doubles per retry while the result stays within 65535, then holds.
// - Read-only auth type shows 0xc023 or 0xc223.
// - Read-only register shows the PPP auth algorithm used.
// - LCP echo interval resets to 0x28, 25 ms per count.
// - Magic-number register feeds the LCP magic-number option.
// - Read-only register returns a fixed chip version.
// - Re-assert wait is low byte plus one cycles, also when zero; high byte unused.
// - Clearing socket flags releases the line, re-asserts after delay.
// - Summary bit sets on socket event, clears with socket flags.
// - Link-closed event only counts while PPPoE mode bit is one.
`timescale 1ns/100ps
`default_nettype none
module nirq_core #(
   parameter int RETRY_UNIT_CYCLES = nirq_pkg::RETRY_UNIT_CYCLES,
   parameter int LCP_UNIT_CYCLES = nirq_pkg::LCP_UNIT_CYCLES,
   // Arbitrary value, not tied to any part
   parameter logic [7:0] CHIP_VERSION = 8'h5a
) (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic [23:0] ADDR,
   input wire logic [7:0] WR_DATA,
   input wire logic WR_STROBE,
   input wire logic RD_STROBE,
   output logic [7:0] RD_DATA,
   input wire logic ARP_IP_CONFLICT,
   input wire logic ICMP_UNREACHABLE,
   input wire logic PPP_LINK_CLOSED,
   input wire logic PPPOE_MODE,
   input wire logic [7:0] SOCKET_EVENT_SET,
   input wire logic [7:0] SOCKET_EVENT_FLAGS_ZERO,
   input wire logic PPP_AUTH_VALID,
   input wire logic [15:0] PPP_AUTH_TYPE_IN,
   input wire logic [7:0] PPP_AUTH_ALGORITHM_IN,
   input wire logic RETRY_START,
   input wire logic RETRY_IS_TCP,
   input wire logic [2:0] RETRY_SOCKET,
   input wire logic RETRY_ACK,
   output logic RETRY_RESEND,
   output logic [7:0] SOCKET_TIMEOUT,
   output logic [7:0] SOCKET_STATE_CLOSED,
   output logic LCP_ECHO_REQUEST,
   output logic [7:0] LCP_MAGIC_NUMBER,
   output logic [7:0] SOCKET_SUMMARY_FLAGS,
   output logic CORE_IRQ_LINE_N
);

   logic [7:0] interrupt_cause_r;
   logic [7:0] socket_interrupt_mask_r;
   logic [15:0] retry_period_r;
   logic [7:0] retry_limit_r;
   logic [15:0] ppp_auth_type_r;
   logic [7:0] ppp_auth_algorithm_r;
   logic [7:0] lcp_echo_interval_r;
   logic [15:0] interrupt_reassert_delay_r;
   logic [7:0] socket_summary_r;
   logic [7:0] socket_summary_nxt;
   logic [7:0] cause_set;
   logic [7:0] cause_clear;
   logic [7:0] read_value;
   logic wr_cause;
   logic pending;
   logic summary_dropped;
   logic retry_tick;
   logic lcp_tick;
   logic retry_busy;
   nirq_pkg::nirq_line_type line_r;
   logic [7:0] reassert_wait_r;
   logic [7:0] echo_count_r;

   assign wr_cause = WR_STROBE && ADDR == nirq_pkg::ADDR_INTERRUPT_CAUSE;

   // Event sources into the cause register
   always_comb begin
      cause_set = 8'h00;
      cause_set[nirq_pkg::CAUSE_CONFLICT_BIT] = ARP_IP_CONFLICT;
      cause_set[nirq_pkg::CAUSE_DEST_UNREACHABLE_FLAG_BIT] = ICMP_UNREACHABLE;
      cause_set[nirq_pkg::CAUSE_LINK_CLOSED_BIT] = PPP_LINK_CLOSED && PPPOE_MODE;
      cause_clear = wr_cause ? (WR_DATA & nirq_pkg::CAUSE_IMPL_MASK) : 8'h00;
   end

   // Set wins over a same-cycle write-one clear
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         interrupt_cause_r <= nirq_pkg::RST_INTERRUPT_CAUSE;
      end else begin
         interrupt_cause_r <= ((interrupt_cause_r & ~cause_clear) | cause_set)
                              & nirq_pkg::CAUSE_IMPL_MASK;
      end
   end

   // Summary bits follow the socket flags; set wins over clear
   always_comb begin
      socket_summary_nxt = (socket_summary_r & ~SOCKET_EVENT_FLAGS_ZERO)
                           | SOCKET_EVENT_SET;
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         socket_summary_r <= 8'h00;
         SOCKET_SUMMARY_FLAGS <= 8'h00;
      end else begin
         socket_summary_r <= socket_summary_nxt;
         SOCKET_SUMMARY_FLAGS <= socket_summary_nxt;
      end
   end

   // Software-written configuration
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         socket_interrupt_mask_r <= nirq_pkg::RST_SOCKET_INTERRUPT_MASK;
         retry_period_r <= nirq_pkg::RST_RETRY_PERIOD;
         retry_limit_r <= nirq_pkg::RST_RETRY_LIMIT;
         lcp_echo_interval_r <= nirq_pkg::RST_LCP_ECHO_INTERVAL;
         LCP_MAGIC_NUMBER <= nirq_pkg::RST_LCP_MAGIC_NUMBER;
         interrupt_reassert_delay_r <= nirq_pkg::RST_REASSERT_DELAY;
      end else if (WR_STROBE) begin
         case (ADDR)
            nirq_pkg::ADDR_SOCKET_INTERRUPT_MASK: socket_interrupt_mask_r <= WR_DATA;
            nirq_pkg::ADDR_RETRY_PERIOD_HI: retry_period_r[15:8] <= WR_DATA;
            nirq_pkg::ADDR_RETRY_PERIOD_LO: retry_period_r[7:0] <= WR_DATA;
            nirq_pkg::ADDR_RETRY_LIMIT: retry_limit_r <= WR_DATA;
            nirq_pkg::ADDR_LCP_ECHO_INTERVAL: lcp_echo_interval_r <= WR_DATA;
            nirq_pkg::ADDR_LCP_MAGIC_NUMBER: LCP_MAGIC_NUMBER <= WR_DATA;
            nirq_pkg::ADDR_REASSERT_DELAY_HI: interrupt_reassert_delay_r[15:8] <= WR_DATA;
            nirq_pkg::ADDR_REASSERT_DELAY_LO: interrupt_reassert_delay_r[7:0] <= WR_DATA;
            default: begin
            end
         endcase
      end
   end

   // Negotiated PPP results, captured from the link logic
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         ppp_auth_type_r <= nirq_pkg::RST_PPP_AUTH_TYPE;
         ppp_auth_algorithm_r <= nirq_pkg::RST_PPP_AUTH_ALGORITHM;
      end else if (PPP_AUTH_VALID) begin
         // Only the two supported methods are reported
         if (PPP_AUTH_TYPE_IN == nirq_pkg::AUTH_TYPE_PASSWORD
             || PPP_AUTH_TYPE_IN == nirq_pkg::AUTH_TYPE_CHALLENGE) begin
            ppp_auth_type_r <= PPP_AUTH_TYPE_IN;
         end
         ppp_auth_algorithm_r <= PPP_AUTH_ALGORITHM_IN;
      end
   end

   // Read mux; 16-bit registers hold the high byte at the lower address
   always_comb begin
      case (ADDR)
         nirq_pkg::ADDR_INTERRUPT_CAUSE: read_value = interrupt_cause_r;
         nirq_pkg::ADDR_SOCKET_INTERRUPT_MASK: read_value = socket_interrupt_mask_r;
         nirq_pkg::ADDR_RETRY_PERIOD_HI: read_value = retry_period_r[15:8];
         nirq_pkg::ADDR_RETRY_PERIOD_LO: read_value = retry_period_r[7:0];
         nirq_pkg::ADDR_RETRY_LIMIT: read_value = retry_limit_r;
         nirq_pkg::ADDR_PPP_AUTH_TYPE_HI: read_value = ppp_auth_type_r[15:8];
         nirq_pkg::ADDR_PPP_AUTH_TYPE_LO: read_value = ppp_auth_type_r[7:0];
         nirq_pkg::ADDR_PPP_AUTH_ALGORITHM: read_value = ppp_auth_algorithm_r;
         nirq_pkg::ADDR_CHIP_VERSION: read_value = CHIP_VERSION;
         nirq_pkg::ADDR_LCP_ECHO_INTERVAL: read_value = lcp_echo_interval_r;
         nirq_pkg::ADDR_LCP_MAGIC_NUMBER: read_value = LCP_MAGIC_NUMBER;
         nirq_pkg::ADDR_REASSERT_DELAY_HI: read_value = interrupt_reassert_delay_r[15:8];
         nirq_pkg::ADDR_REASSERT_DELAY_LO: read_value = interrupt_reassert_delay_r[7:0];
         nirq_pkg::ADDR_SOCKET_SUMMARY: read_value = socket_summary_r;
         default: read_value = 8'h00;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         RD_DATA <= 8'h00;
      end else if (RD_STROBE) begin
         RD_DATA <= read_value;
      end else begin
         RD_DATA <= 8'h00;
      end
   end

   // Interrupt line control
   assign pending = (|interrupt_cause_r)
                    || (|(socket_summary_r & socket_interrupt_mask_r));
   // A masked summary bit falling forces a visible release
   assign summary_dropped = |(socket_summary_r & ~socket_summary_nxt
                              & socket_interrupt_mask_r);

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         line_r <= nirq_pkg::LINE_IDLE;
         reassert_wait_r <= 8'h00;
         CORE_IRQ_LINE_N <= 1'b1;
      end else begin
         case (line_r)
            nirq_pkg::LINE_IDLE: begin
               CORE_IRQ_LINE_N <= 1'b1;
               if (pending) begin
                  line_r <= nirq_pkg::LINE_ASSERTED;
                  CORE_IRQ_LINE_N <= 1'b0;
               end
            end
            nirq_pkg::LINE_ASSERTED: begin
               if (!pending) begin
                  line_r <= nirq_pkg::LINE_IDLE;
                  CORE_IRQ_LINE_N <= 1'b1;
               end else if (summary_dropped) begin
                  // Release now; wait is low byte plus one high cycles
                  line_r <= nirq_pkg::LINE_WAIT;
                  reassert_wait_r <= interrupt_reassert_delay_r[7:0];
                  CORE_IRQ_LINE_N <= 1'b1;
               end
            end
            nirq_pkg::LINE_WAIT: begin
               if (reassert_wait_r != 8'h00) begin
                  reassert_wait_r <= reassert_wait_r - 8'h01;
               end else if (pending) begin
                  line_r <= nirq_pkg::LINE_ASSERTED;
                  CORE_IRQ_LINE_N <= 1'b0;
               end else begin
                  line_r <= nirq_pkg::LINE_IDLE;
               end
            end
            default: begin
               line_r <= nirq_pkg::LINE_IDLE;
               CORE_IRQ_LINE_N <= 1'b1;
            end
         endcase
      end
   end

   // Retransmission timing
   nirq_tick_divider #(
      .CYCLES(RETRY_UNIT_CYCLES)
   ) retry_unit (
      .clk(CLOCK),
      .rstn(RSTN),
      .restart(RETRY_START && !retry_busy),
      .tick(retry_tick)
   );

   nirq_retry_timer retry_engine (
      .clk(CLOCK),
      .rstn(RSTN),
      .unit_tick(retry_tick),
      .start(RETRY_START),
      .is_tcp(RETRY_IS_TCP),
      .socket(RETRY_SOCKET),
      .ack(RETRY_ACK),
      .period(retry_period_r),
      .limit(retry_limit_r),
      .resend(RETRY_RESEND),
      .timeout(SOCKET_TIMEOUT),
      .close(SOCKET_STATE_CLOSED),
      .busy(retry_busy)
   );

   // LCP echo pacing, only while PPPoE mode is on
   nirq_tick_divider #(
      .CYCLES(LCP_UNIT_CYCLES)
   ) lcp_unit (
      .clk(CLOCK),
      .rstn(RSTN),
      .restart(!PPPOE_MODE),
      .tick(lcp_tick)
   );

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         echo_count_r <= 8'h00;
         LCP_ECHO_REQUEST <= 1'b0;
      end else begin
         LCP_ECHO_REQUEST <= 1'b0;
         if (!PPPOE_MODE || lcp_echo_interval_r == 8'h00) begin
            echo_count_r <= 8'h00;
         end else if (lcp_tick) begin
            if (echo_count_r + 8'h01 >= lcp_echo_interval_r) begin
               echo_count_r <= 8'h00;
               LCP_ECHO_REQUEST <= 1'b1;
            end else begin
               echo_count_r <= echo_count_r + 8'h01;
            end
         end
      end
   end

endmodule // nirq_core
`default_nettype wire

// ### nirq_chk.sv
`timescale 1ns/100ps
`default_nettype none
module nirq_chk #(
   parameter logic [7:0] CHIP_VERSION = 8'h5a
) (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic [23:0] ADDR,
   input wire logic [7:0] WR_DATA,
   input wire logic WR_STROBE,
   input wire logic RD_STROBE,
   input wire logic [7:0] RD_DATA,
   input wire logic ARP_IP_CONFLICT,
   input wire logic ICMP_UNREACHABLE,
   input wire logic PPPOE_MODE,
   input wire logic [7:0] SOCKET_EVENT_SET,
   input wire logic [7:0] SOCKET_EVENT_FLAGS_ZERO,
   input wire logic [7:0] SOCKET_TIMEOUT,
   input wire logic [7:0] SOCKET_STATE_CLOSED,
   input wire logic LCP_ECHO_REQUEST,
   input wire logic [7:0] LCP_MAGIC_NUMBER,
   input wire logic [7:0] SOCKET_SUMMARY_FLAGS,
   input wire logic CORE_IRQ_LINE_N
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   logic [7:0] lo_r, msk_r;
   logic [8:0] hi_r;
   logic pend;
   // Bus write shadows
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         lo_r <= 8'h00;
         msk_r <= 8'h00;
      end else if (WR_STROBE) begin
         if (ADDR == nirq_pkg::ADDR_REASSERT_DELAY_LO) lo_r <= WR_DATA;
         if (ADDR == nirq_pkg::ADDR_SOCKET_INTERRUPT_MASK) msk_r <= WR_DATA;
      end
   end
   // Saturates so a long idle never wraps into a short wait
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) hi_r <= 9'h1ff;
      else if (!CORE_IRQ_LINE_N) hi_r <= 9'h000;
      else if (hi_r != 9'h1ff) hi_r <= hi_r + 9'h001;
   end
   assign pend = |(SOCKET_SUMMARY_FLAGS & msk_r);
   sequence release_s;
      $rose(CORE_IRQ_LINE_N) && pend;
   endsequence
   sequence drop_s;
      !CORE_IRQ_LINE_N ##1 |($past(SOCKET_SUMMARY_FLAGS) & ~SOCKET_SUMMARY_FLAGS & msk_r);
   endsequence
   sequence wait_done_s;
      $fell(CORE_IRQ_LINE_N) && hi_r == {1'b0, lo_r} + 9'h001;
   endsequence
   event_line_a: assert property (
      (ARP_IP_CONFLICT || ICMP_UNREACHABLE) |-> ##[1:260] !CORE_IRQ_LINE_N)
      else $error("line not low after cause event");
   reassert_wait_a: assert property (
      release_s |-> ##[1:257] wait_done_s)
      else $error("re-assert wait wrong");
   release_line_a: assert property (
      drop_s |-> ##[0:1] CORE_IRQ_LINE_N)
      else $error("line not released on summary drop");
   cause_rsvd_a: assert property (
      RD_STROBE && ADDR == nirq_pkg::ADDR_INTERRUPT_CAUSE |=> RD_DATA[4:0] == 5'h00)
      else $error("reserved cause bits set");
   version_rd_a: assert property (
      RD_STROBE && ADDR == nirq_pkg::ADDR_CHIP_VERSION |=> RD_DATA == CHIP_VERSION)
      else $error("version read wrong");
   magic_port_a: assert property (
      WR_STROBE && ADDR == nirq_pkg::ADDR_LCP_MAGIC_NUMBER
      |=> LCP_MAGIC_NUMBER == $past(WR_DATA))
      else $error("magic output stale");
   summary_set_a: assert property (
      SOCKET_EVENT_SET[0] |-> ##[1:2] SOCKET_SUMMARY_FLAGS[0])
      else $error("summary bit not set");
   summary_clr_a: assert property (
      (SOCKET_EVENT_FLAGS_ZERO[0] && !SOCKET_EVENT_SET[0])[*4] |-> !SOCKET_SUMMARY_FLAGS[0])
      else $error("summary bit not cleared");
   close_timeout_a: assert property (
      (SOCKET_STATE_CLOSED & ~SOCKET_TIMEOUT) == 8'h00)
      else $error("close without timeout");
   echo_off_a: assert property (
      !PPPOE_MODE [*3] |-> !LCP_ECHO_REQUEST)
      else $error("echo outside link mode");
endmodule // nirq_chk
`default_nettype wire

// ### nirq_mcu.sv
`timescale 1ns/100ps
`default_nettype none
module nirq_mcu (
   input wire logic clk,
   output logic [23:0] addr,
   output logic [7:0] wr_data,
   output logic wr_strobe,
   output logic rd_strobe
);
   logic [7:0] exp_q[$];
   initial {addr, wr_data, wr_strobe, rd_strobe} = 34'h0;
   task automatic wr(input logic [7:0] a, d);
      addr <= {16'hfe00, a};
      wr_data <= d;
      wr_strobe <= 1'b1;
      @(posedge clk);
      wr_strobe <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, e);
      exp_q.push_back(e);
      addr <= {16'hfe00, a};
      rd_strobe <= 1'b1;
      @(posedge clk);
      rd_strobe <= 1'b0;
      @(posedge clk);
   endtask
   // Writes high byte 0x2c, then the low byte; only the low byte sets the re-assert wait
   task automatic set_delay(input logic [7:0] lo);
      wr(8'h30, 8'h2c);
      wr(8'h31, lo);
   endtask
endmodule // nirq_mcu
`default_nettype wire

// ### tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam logic [7:0] VER = 8'h3c; // Arbitrary version value
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [23:0] addr;
   logic [7:0] wr_data, rd_data, sum, to_v, cl_v, magic, d;
   logic wr_s, rd_s, line_n, resend, echo;
   logic rd_d = 1'b0, mode = 1'b0, tcp = 1'b0;
   logic [5:0] ev = 6'h00;
   logic [2:0] sock = 3'h0;
   logic [7:0] set = 8'h00, zero = 8'hff, alg = 8'h00, to_acc = 8'h00, cl_acc = 8'h00;
   logic [15:0] atype = 16'h0000;
   int failures = 0, cmp_count = 0, cyc = 0, i, n;
   int tq[$], eq[$];
   logic [7:0] ra[14] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1c, 8'h1d, 8'h1e, 8'h1f,
      8'h28, 8'h29, 8'h30, 8'h31, 8'h20};
   logic [7:0] rv[14] = '{8'h00, 8'h00, 8'h07, 8'hd0, 8'h08, 8'h00, 8'h00, 8'h00, VER,
      8'h28, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] wa[8] = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h28, 8'h29, 8'h30, 8'h31};
   logic [7:0] oa[5] = '{8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h34};
   logic [7:0] ov[5] = '{8'h00, 8'h00, 8'h00, VER, 8'h00};
   logic [15:0] at[3] = '{16'hc023, 16'h1234, 16'hc223};
   logic [15:0] et[3] = '{16'hc023, 16'hc023, 16'hc223};

   always #4 clk = ~clk;

   nirq_mcu i_nirq_mcu (.clk(clk), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_s),
      .rd_strobe(rd_s));
   nirq_core #(.RETRY_UNIT_CYCLES(4), .LCP_UNIT_CYCLES(2), .CHIP_VERSION(VER)) i_nirq_core (
      .CLOCK(clk), .RSTN(rstn), .ADDR(addr), .WR_DATA(wr_data), .WR_STROBE(wr_s),
      .RD_STROBE(rd_s), .RD_DATA(rd_data), .ARP_IP_CONFLICT(ev[0]),
      .ICMP_UNREACHABLE(ev[1]), .PPP_LINK_CLOSED(ev[2]), .PPPOE_MODE(mode),
      .SOCKET_EVENT_SET(set), .SOCKET_EVENT_FLAGS_ZERO(zero), .PPP_AUTH_VALID(ev[3]),
      .PPP_AUTH_TYPE_IN(atype), .PPP_AUTH_ALGORITHM_IN(alg), .RETRY_START(ev[4]),
      .RETRY_IS_TCP(tcp), .RETRY_SOCKET(sock), .RETRY_ACK(ev[5]), .RETRY_RESEND(resend),
      .SOCKET_TIMEOUT(to_v), .SOCKET_STATE_CLOSED(cl_v), .LCP_ECHO_REQUEST(echo),
      .LCP_MAGIC_NUMBER(magic), .SOCKET_SUMMARY_FLAGS(sum), .CORE_IRQ_LINE_N(line_n));

   task chk(input string nm, input logic [15:0] e, s);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task summarize;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task w(input logic [7:0] a, v);
      i_nirq_mcu.wr(a, v);
   endtask
   task r(input logic [7:0] a, e);
      i_nirq_mcu.rd(a, e);
   endtask
   task pulse(input int b);
      ev[b] <= 1'b1;
      @(posedge clk);
      ev[b] <= 1'b0;
      @(posedge clk);
   endtask
   task sset(input logic [7:0] v);
      set <= v;
      @(posedge clk);
      set <= 8'h00;
      @(posedge clk);
   endtask
   // Falling edge, away from the recorder
   task clr;
      @(negedge clk);
      tq.delete();
      eq.delete();
      to_acc = 8'h00;
      cl_acc = 8'h00;
      @(posedge clk);
   endtask
   task hi_run(input logic [15:0] e);
      n = 0;
      for (i = 0; i < 6 && line_n !== 1'b1; i++) @(negedge clk);
      while (line_n === 1'b1 && n < 300) begin
         n++;
         @(negedge clk);
      end
      chk("line high cycles", e, 16'(n));
      @(posedge clk);
   endtask
   task wt;
      for (i = 0; i < 300 && to_acc === 8'h00; i++) @(posedge clk);
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rd_d) chk("read data", {8'h00, i_nirq_mcu.exp_q.pop_front()}, {8'h00, rd_data});
      rd_d <= rd_s;
      if (resend === 1'b1 || to_v != 8'h00) tq.push_back(cyc);
      if (echo === 1'b1) eq.push_back(cyc);
      to_acc <= to_acc | to_v;
      cl_acc <= cl_acc | cl_v;
      if (cyc == 40000) begin
         failures++;
         summarize();
      end
   end

   initial begin
      void'($urandom(99));
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      foreach (ra[k]) r(ra[k], rv[k]);
      $display("reset values done");
      foreach (wa[k]) begin
         d = 8'($urandom);
         w(wa[k], d);
         r(wa[k], d);
         if (wa[k] == 8'h29) chk("magic out", {8'h00, d}, {8'h00, magic});
      end
      foreach (oa[k]) begin
         w(oa[k], 8'($urandom));
         r(oa[k], ov[k]);
      end
      $display("access kinds done");
      w(8'h16, 8'h00);
      pulse(2);
      r(8'h15, 8'h00);
      mode <= 1'b1;
      pulse(0);
      pulse(1);
      pulse(2);
      r(8'h15, 8'he0);
      chk("line low", 16'h0000, {15'h0, line_n});
      w(8'h15, 8'h9f);
      r(8'h15, 8'h60);
      chk("line held", 16'h0000, {15'h0, line_n});
      w(8'h15, 8'h60);
      r(8'h15, 8'h00);
      chk("line freed", 16'h0001, {15'h0, line_n});
      $display("cause test done");
      i_nirq_mcu.set_delay(8'h0f);
      w(8'h16, 8'h03);
      zero <= 8'hfc;
      sset(8'h03);
      r(8'h34, 8'h03);
      chk("summary line", 16'h0000, {15'h0, line_n});
      zero <= 8'hfd;
      hi_run(16'h0010);
      i_nirq_mcu.set_delay(8'h00);
      zero <= 8'hfc;
      sset(8'h01);
      zero <= 8'hfd;
      hi_run(16'h0001);
      zero <= 8'hff;
      @(posedge clk);
      r(8'h34, 8'h00);
      chk("all clear", 16'h0001, {15'h0, line_n});
      w(8'h16, 8'h00);
      zero <= 8'hfb;
      sset(8'h04);
      repeat (6) @(posedge clk);
      chk("masked", 16'h0001, {15'h0, line_n});
      r(8'h34, 8'h04);
      zero <= 8'hff;
      $display("summary test done");
      w(8'h17, 8'h00);
      w(8'h18, 8'h02);
      w(8'h19, 8'h01);
      clr();
      sock <= 3'h3;
      tcp <= 1'b0;
      pulse(4);
      wt();
      chk("arp timeout", 16'h0008, {8'h00, to_acc});
      chk("arp close", 16'h0000, {8'h00, cl_acc});
      chk("arp sends", 16'h0002, 16'(tq.size()));
      chk("arp wait", 16'h0008, 16'(tq[1] - tq[0]));
      w(8'h19, 8'h02);
      clr();
      sock <= 3'h5;
      tcp <= 1'b1;
      pulse(4);
      wt();
      chk("tcp timeout", 16'h0020, {8'h00, to_acc});
      chk("tcp close", 16'h0020, {8'h00, cl_acc});
      chk("tcp sends", 16'h0003, 16'(tq.size()));
      chk("tcp wait 2", 16'h0010, 16'(tq[1] - tq[0]));
      chk("tcp wait 3", 16'h0020, 16'(tq[2] - tq[1]));
      clr();
      pulse(4);
      pulse(5);
      repeat (60) @(posedge clk);
      chk("acked", 16'h0000, 16'(tq.size()));
      $display("retry test done");
      for (n = 0; n < 3; n++) begin
         atype <= at[n];
         alg <= 8'($urandom);
         pulse(3);
         r(8'h1c, et[n][15:8]);
         r(8'h1d, et[n][7:0]);
         r(8'h1e, alg);
      end
      $display("auth test done");
      clr();
      w(8'h28, 8'h03);
      repeat (30) @(posedge clk);
      chk("echo gap", 16'h0006, 16'(eq[2] - eq[1]));
      mode <= 1'b0;
      repeat (5) @(posedge clk);
      $display("echo test done");
      summarize();
   end
endmodule // tb

bind nirq_core nirq_chk #(.CHIP_VERSION(CHIP_VERSION)) i_nirq_chk (.*);
`default_nettype wire
